// ==== design/dtic_pkg.sv ====
// package of register map, field positions and timing constants for the dual timer block
package dtic_pkg;
   // apb byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_LB0 = 8'h08;
   localparam logic [7:0] OFS_HB0 = 8'h0C;
   localparam logic [7:0] OFS_LB1 = 8'h10;
   localparam logic [7:0] OFS_HB1 = 8'h14;
   localparam logic [7:0] OFS_IEN = 8'h18;
   localparam logic [7:0] OFS_IPR = 8'h1C;
   localparam logic [7:0] OFS_SER = 8'h20;
   localparam logic [7:0] OFS_IRQ = 8'h24;
   // counter control field positions
   localparam int B_OV1 = 7;
   localparam int B_RN1 = 6;
   localparam int B_OV0 = 5;
   localparam int B_RN0 = 4;
   localparam int B_XF1 = 3;
   localparam int B_XT1 = 2;
   localparam int B_XF0 = 1;
   localparam int B_XT0 = 0;
   // counter mode field positions (timer 1 at +4)
   localparam int B_GATE = 3;
   localparam int B_CT = 2;
   localparam int B_MH = 1;
   localparam int B_ML = 0;
   localparam int TMR1_SHIFT = 4;
   // enable / priority layout
   localparam int B_GE = 7;
   localparam logic [7:0] IEN_MASK = 8'h9F;
   localparam logic [7:0] IPR_MASK = 8'h1F;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // machine cycle: twelve clocks, late sample at phase index 9
   localparam int MC_CLOCKS = 12;
   localparam logic [3:0] MC_LAST = 4'(MC_CLOCKS - 1);
   localparam logic [3:0] MC_SAMPLE = 4'h9;
   localparam int NSRC = 5;
   // vector index of each source (fixed order 0 first)
   localparam logic [2:0] SRC_EXT0 = 3'h0;
   localparam logic [2:0] SRC_TMR0 = 3'h1;
   localparam logic [2:0] SRC_EXT1 = 3'h2;
   localparam logic [2:0] SRC_TMR1 = 3'h3;
   localparam logic [2:0] SRC_SER = 3'h4;
   typedef enum logic [1:0] {MODE_13, MODE_16, MODE_RELOAD, MODE_SPLIT} dtic_mode_t;
endpackage : dtic_pkg

// ==== design/dtic_cnt_if.sv ====
// interface joining the top to one 8-bit counting byte
`timescale 1ns/1ps
`default_nettype none
interface dtic_cnt_if;
   logic inc;
   logic load;
   logic [7:0] load_val;
   logic [7:0] value;
   logic wrap;
   modport owner (output inc, output load, output load_val, input value, input wrap);
   modport cnt (input inc, input load, input load_val, output value, output wrap);
endinterface : dtic_cnt_if
`default_nettype wire

// ==== design/dtic_byte_cnt.sv ====
// one 8-bit count byte with load and wrap pulse
`timescale 1ns/1ps
`default_nettype none
module dtic_byte_cnt (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic [7:0] wrap_at, // value after which the byte wraps
   dtic_cnt_if.cnt bus // control and value
);
   // load has priority so software writes are never lost to a count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus.value <= 8'h00;
      end else if (bus.load) begin
         bus.value <= bus.load_val;
      end else if (bus.inc) begin
         bus.value <= ((bus.value & wrap_at) == wrap_at) ? 8'h00 : bus.value + 8'h01;
      end
   end

   // wrap ignores load so a reload driven by it cannot loop back
   assign bus.wrap = bus.inc && ((bus.value & wrap_at) == wrap_at);
endmodule : dtic_byte_cnt
`default_nettype wire

// ==== design/dtic_top.sv ====
// dual timer/counter with interrupt request logic behind an apb slave
`timescale 1ns/1ps
`default_nettype none
module dtic_top (
   input wire logic pclk, // 50 MHz clock
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic count_pin0, // timer 0 external count input
   input wire logic count_pin1, // timer 1 external count input
   input wire logic ext_request_pin0, // external request 0, low active
   input wire logic ext_request_pin1, // external request 1, low active
   input wire logic vector_ack, // core vectors to the source below
   input wire logic [2:0] vector_src, // source being vectored
   input wire logic isr_return, // core returns from a service routine
   output logic irq_valid, // a request wins the poll
   output logic [2:0] irq_src, // winning source
   output logic irq_high, // winner is high level
   output logic mc_tick // machine cycle pulse for baud use
);
   logic [7:0] counter_control_reg;
   logic [7:0] counter_mode_reg;
   logic [7:0] interrupt_enable_reg;
   logic [7:0] interrupt_priority_reg;
   logic serial_rx_done;
   logic serial_tx_done;
   logic [3:0] phase;
   logic late_phase_sample_point;
   logic [1:0] ext_smp;
   logic [1:0] ext_prev;
   logic [1:0] cnt_smp;
   logic [1:0] cnt_prev;
   logic [1:0] in_service;
   logic wr;
   logic rd;
   logic mapped;
   logic [31:0] next_rdata;
   logic [3:0] hw_set;
   logic [3:0] hw_clr;
   logic [1:0] ext_edge;
   logic [1:0] run;
   logic [1:0] ev;
   logic [4:0] req;
   logic [2:0] next_src;
   logic next_valid;
   logic next_high;
   logic [7:0] wrap_lo0;
   logic [7:0] wrap_lo1;
   dtic_pkg::dtic_mode_t mode0;
   dtic_pkg::dtic_mode_t mode1;

   dtic_cnt_if lo0 ();
   dtic_cnt_if hi0 ();
   dtic_cnt_if lo1 ();
   dtic_cnt_if hi1 ();

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign mode0 = dtic_pkg::dtic_mode_t'(counter_mode_reg[dtic_pkg::B_MH:dtic_pkg::B_ML]);
   assign mode1 = dtic_pkg::dtic_mode_t'(counter_mode_reg[dtic_pkg::B_MH + dtic_pkg::TMR1_SHIFT -:
      2]);
   assign late_phase_sample_point = (phase == dtic_pkg::MC_SAMPLE);

   // machine cycle divider; one pclk of each twelve is the late sampling phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 4'h0;
      end else begin
         phase <= (phase == dtic_pkg::MC_LAST) ? 4'h0 : phase + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_tick <= 1'b0;
      end else begin
         mc_tick <= late_phase_sample_point;
      end
   end

   // pins sampled once per machine cycle at the late phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_smp <= 2'b11;
         ext_prev <= 2'b11;
         cnt_smp <= 2'b00;
         cnt_prev <= 2'b00;
      end else if (late_phase_sample_point) begin
         ext_prev <= ext_smp;
         ext_smp <= {ext_request_pin1, ext_request_pin0};
         cnt_prev <= cnt_smp;
         cnt_smp <= {count_pin1, count_pin0};
      end
   end

   // per-timer run and count event; counter mode counts sampled falling edges
   for (genvar t = 0; t < 2; t++) begin : g_gate
      localparam int S = t * dtic_pkg::TMR1_SHIFT;
      logic tr;
      assign tr = counter_control_reg[t == 0 ? dtic_pkg::B_RN0 : dtic_pkg::B_RN1];
      assign run[t] = tr && (!counter_mode_reg[dtic_pkg::B_GATE + S] || ext_smp[t]);
      assign ev[t] = counter_mode_reg[dtic_pkg::B_CT + S] ?
         (cnt_prev[t] && !cnt_smp[t]) : 1'b1;
      assign ext_edge[t] = ext_prev[t] && !ext_smp[t];
   end

   // mode 0 wraps the low byte after five bits, other modes after eight
   assign wrap_lo0 = (mode0 == dtic_pkg::MODE_13) ? 8'h1F : 8'hFF;
   assign wrap_lo1 = (mode1 == dtic_pkg::MODE_13) ? 8'h1F : 8'hFF;

   dtic_byte_cnt u_lo0 (.pclk(pclk), .presetn(presetn), .wrap_at(wrap_lo0), .bus(lo0.cnt));
   dtic_byte_cnt u_hi0 (.pclk(pclk), .presetn(presetn), .wrap_at(8'hFF), .bus(hi0.cnt));
   dtic_byte_cnt u_lo1 (.pclk(pclk), .presetn(presetn), .wrap_at(wrap_lo1), .bus(lo1.cnt));
   dtic_byte_cnt u_hi1 (.pclk(pclk), .presetn(presetn), .wrap_at(8'hFF), .bus(hi1.cnt));

   // timer 0 stepping; split mode gives the high byte timer 1's run bit
   always_comb begin
      lo0.inc = late_phase_sample_point && run[0] && ev[0];
      hi0.inc = 1'b0;
      lo0.load = wr && (paddr == dtic_pkg::OFS_LB0);
      lo0.load_val = pwdata[7:0];
      hi0.load = wr && (paddr == dtic_pkg::OFS_HB0);
      hi0.load_val = pwdata[7:0];
      case (mode0)
         dtic_pkg::MODE_13: hi0.inc = lo0.wrap;
         dtic_pkg::MODE_16: hi0.inc = lo0.wrap;
         dtic_pkg::MODE_RELOAD: begin
            if (lo0.wrap && !lo0.load) begin
               lo0.load = 1'b1;
               lo0.load_val = hi0.value;
            end
         end
         dtic_pkg::MODE_SPLIT: hi0.inc = late_phase_sample_point &&
            counter_control_reg[dtic_pkg::B_RN1];
         default: hi0.inc = 1'b0;
      endcase
   end

   // timer 1 stepping; its own split mode freezes it like a cleared run bit
   always_comb begin
      lo1.inc = late_phase_sample_point && run[1] && ev[1] &&
         (mode1 != dtic_pkg::MODE_SPLIT);
      hi1.inc = 1'b0;
      lo1.load = wr && (paddr == dtic_pkg::OFS_LB1);
      lo1.load_val = pwdata[7:0];
      hi1.load = wr && (paddr == dtic_pkg::OFS_HB1);
      hi1.load_val = pwdata[7:0];
      case (mode1)
         dtic_pkg::MODE_13: hi1.inc = lo1.wrap;
         dtic_pkg::MODE_16: hi1.inc = lo1.wrap;
         dtic_pkg::MODE_RELOAD: begin
            if (lo1.wrap && !lo1.load) begin
               lo1.load = 1'b1;
               lo1.load_val = hi1.value;
            end
         end
         default: hi1.inc = 1'b0;
      endcase
   end

   // hardware flag events: order ovf1, ovf0, ext1, ext0
   always_comb begin
      hw_set = 4'h0;
      hw_clr = 4'h0;
      // overflow set on the late phase step that wraps
      hw_set[3] = (mode0 == dtic_pkg::MODE_SPLIT) ? hi0.wrap :
         (mode1 == dtic_pkg::MODE_RELOAD ? lo1.wrap : hi1.wrap);
      hw_set[2] = (mode0 == dtic_pkg::MODE_RELOAD || mode0 == dtic_pkg::MODE_SPLIT) ?
         lo0.wrap : hi0.wrap;
      hw_set[1] = late_phase_sample_point && (counter_control_reg[dtic_pkg::B_XT1] ?
         ext_edge[1] : !ext_smp[1]);
      hw_set[0] = late_phase_sample_point && (counter_control_reg[dtic_pkg::B_XT0] ?
         ext_edge[0] : !ext_smp[0]);
      // vectoring clears timer flags and edge flags only
      hw_clr[3] = vector_ack && (vector_src == dtic_pkg::SRC_TMR1);
      hw_clr[2] = vector_ack && (vector_src == dtic_pkg::SRC_TMR0);
      hw_clr[1] = vector_ack && (vector_src == dtic_pkg::SRC_EXT1) &&
         counter_control_reg[dtic_pkg::B_XT1];
      hw_clr[0] = vector_ack && (vector_src == dtic_pkg::SRC_EXT0) &&
         counter_control_reg[dtic_pkg::B_XT0];
   end

   // control register; a hardware set beats a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_control_reg <= dtic_pkg::RST_ZERO;
      end else begin
         if (wr && paddr == dtic_pkg::OFS_CTRL) begin
            counter_control_reg <= pwdata[7:0];
         end
         counter_control_reg[dtic_pkg::B_OV1] <= hw_set[3] || (!hw_clr[3] &&
            (wr && paddr == dtic_pkg::OFS_CTRL ? pwdata[dtic_pkg::B_OV1] :
            counter_control_reg[dtic_pkg::B_OV1]));
         counter_control_reg[dtic_pkg::B_OV0] <= hw_set[2] || (!hw_clr[2] &&
            (wr && paddr == dtic_pkg::OFS_CTRL ? pwdata[dtic_pkg::B_OV0] :
            counter_control_reg[dtic_pkg::B_OV0]));
         counter_control_reg[dtic_pkg::B_XF1] <= hw_set[1] || (!hw_clr[1] &&
            (wr && paddr == dtic_pkg::OFS_CTRL ? pwdata[dtic_pkg::B_XF1] :
            counter_control_reg[dtic_pkg::B_XF1]));
         counter_control_reg[dtic_pkg::B_XF0] <= hw_set[0] || (!hw_clr[0] &&
            (wr && paddr == dtic_pkg::OFS_CTRL ? pwdata[dtic_pkg::B_XF0] :
            counter_control_reg[dtic_pkg::B_XF0]));
      end
   end

   // mode, enable, priority and serial flags are plain software state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_mode_reg <= dtic_pkg::RST_ZERO;
         interrupt_enable_reg <= dtic_pkg::RST_ZERO;
         interrupt_priority_reg <= dtic_pkg::RST_ZERO;
         serial_rx_done <= 1'b0;
         serial_tx_done <= 1'b0;
      end else if (wr) begin
         if (paddr == dtic_pkg::OFS_MODE) begin
            counter_mode_reg <= pwdata[7:0];
         end
         if (paddr == dtic_pkg::OFS_IEN) begin
            interrupt_enable_reg <= pwdata[7:0] & dtic_pkg::IEN_MASK;
         end
         if (paddr == dtic_pkg::OFS_IPR) begin
            interrupt_priority_reg <= pwdata[7:0] & dtic_pkg::IPR_MASK;
         end
         if (paddr == dtic_pkg::OFS_SER) begin
            serial_rx_done <= pwdata[0];
            serial_tx_done <= pwdata[1];
         end
      end
   end

   // request vector in fixed order: ext0, tmr0, ext1, tmr1, serial
   assign req = {serial_rx_done || serial_tx_done,
      counter_control_reg[dtic_pkg::B_OV1], counter_control_reg[dtic_pkg::B_XF1],
      counter_control_reg[dtic_pkg::B_OV0], counter_control_reg[dtic_pkg::B_XF0]}
      & interrupt_enable_reg[4:0] & {5{interrupt_enable_reg[dtic_pkg::B_GE]}};

   // resolve: high level first, then low; lowest index wins within a level
   always_comb begin
      next_valid = 1'b0;
      next_high = 1'b0;
      next_src = 3'h0;
      for (int i = dtic_pkg::NSRC - 1; i >= 0; i--) begin
         if (req[i] && !interrupt_priority_reg[i] && !in_service[0] && !in_service[1]) begin
            next_valid = 1'b1;
            next_high = 1'b0;
            next_src = 3'(i);
         end
      end
      for (int i = dtic_pkg::NSRC - 1; i >= 0; i--) begin
         if (req[i] && interrupt_priority_reg[i] && !in_service[1]) begin
            next_valid = 1'b1;
            next_high = 1'b1;
            next_src = 3'(i);
         end
      end
   end

   // poll once per machine cycle, one cycle after the sampling phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_valid <= 1'b0;
         irq_src <= 3'h0;
         irq_high <= 1'b0;
      end else if (mc_tick) begin
         irq_valid <= next_valid;
         irq_src <= next_src;
         irq_high <= next_high;
      end else if (vector_ack) begin
         irq_valid <= 1'b0;
      end
   end

   // levels in service; a return closes the highest open level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_service <= 2'b00;
      end else if (vector_ack) begin
         in_service[interrupt_priority_reg[vector_src]] <= 1'b1;
      end else if (isr_return) begin
         if (in_service[1]) begin
            in_service[1] <= 1'b0;
         end else begin
            in_service[0] <= 1'b0;
         end
      end
   end

   // read mux; captured in setup so prdata is a flop during access
   always_comb begin
      mapped = 1'b1;
      next_rdata = 32'h0000_0000;
      case (paddr)
         dtic_pkg::OFS_CTRL: next_rdata[7:0] = counter_control_reg;
         dtic_pkg::OFS_MODE: next_rdata[7:0] = counter_mode_reg;
         dtic_pkg::OFS_LB0: next_rdata[7:0] = lo0.value;
         dtic_pkg::OFS_HB0: next_rdata[7:0] = hi0.value;
         dtic_pkg::OFS_LB1: next_rdata[7:0] = lo1.value;
         dtic_pkg::OFS_HB1: next_rdata[7:0] = hi1.value;
         dtic_pkg::OFS_IEN: next_rdata[7:0] = interrupt_enable_reg;
         dtic_pkg::OFS_IPR: next_rdata[7:0] = interrupt_priority_reg;
         dtic_pkg::OFS_SER: next_rdata[1:0] = {serial_tx_done, serial_rx_done};
         dtic_pkg::OFS_IRQ: next_rdata[5:0] = {in_service, irq_high, irq_src};
         default: mapped = 1'b0;
      endcase
   end

   // apb answer: ready in the first access cycle, error on unmapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (rd) begin
            prdata <= next_rdata;
         end
      end
   end
endmodule : dtic_top
`default_nettype wire

// ==== sim/dtic_core_model.sv ====
// behavioural core that vectors to the winning request and later returns
`timescale 1ns/1ps
`default_nettype none
module dtic_core_model (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic irq_valid, // request from the block
   input wire logic [2:0] irq_src, // winning source
   input wire logic [3:0] lag, // cycles to wait before vectoring
   output logic vector_ack, // vector pulse
   output logic [2:0] vector_src, // source being vectored
   output logic isr_return // return pulse
);
   logic busy;
   logic [2:0] src;
   int cnt;
   // outside the pulse the source lines carry the inverse so stale values never match
   assign vector_src = vector_ack ? src : ~src;
   // one routine at a time; a slow lag lets the request stand for a while first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         cnt <= 0;
         src <= 3'h0;
         vector_ack <= 1'b0;
         isr_return <= 1'b0;
      end else begin
         vector_ack <= 1'b0;
         isr_return <= 1'b0;
         if (!busy && irq_valid) begin
            cnt <= cnt + 1;
            if (cnt >= int'(lag)) begin
               vector_ack <= 1'b1;
               src <= irq_src;
               busy <= 1'b1;
               cnt <= 0;
            end
         end else if (busy) begin
            cnt <= cnt + 1;
            if (cnt == 30) begin
               isr_return <= 1'b1;
               busy <= 1'b0;
               cnt <= 0;
            end
         end
      end
   end
endmodule : dtic_core_model
`default_nettype wire

// ==== sim/dtic_top_chk.sv ====
// checker on the bus and interrupt request ports of the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dtic_top_chk (
   input wire logic pclk, // clock
   input wire logic presetn, // reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic vector_ack, // core vectors
   input wire logic irq_valid, // request wins the poll
   input wire logic [2:0] irq_src, // winning source
   input wire logic irq_high, // winner level
   input wire logic mc_tick // machine cycle pulse
);
   logic [7:0] ien_q;
   logic [7:0] ipr_q;
   logic [7:0] ien_d;
   logic [7:0] ipr_d;
   logic wr_ok;
   assign wr_ok = psel && penable && pwrite && pready;
   // shadow enables and levels, delayed a cycle so they line up with the poll result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien_q <= 8'h00;
         ipr_q <= 8'h00;
         ien_d <= 8'h00;
         ipr_d <= 8'h00;
      end else begin
         ien_d <= ien_q;
         ipr_d <= ipr_q;
         if (wr_ok && paddr == dtic_pkg::OFS_IEN) ien_q <= pwdata[7:0];
         if (wr_ok && paddr == dtic_pkg::OFS_IPR) ipr_q <= pwdata[7:0];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_next: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_unmapped_err: assert property (psel && !penable && paddr > dtic_pkg::OFS_IRQ |=> pslverr)
      else $error("no error on unmapped address");
   a_tick_period: assert property (mc_tick |-> ##12 mc_tick)
      else $error("machine cycle not twelve clocks");
   a_tick_gap: assert property (mc_tick |=> !mc_tick [*8])
      else $error("machine cycle pulse too early");
   a_rise_at_poll: assert property ($rose(irq_valid) |-> $past(mc_tick))
      else $error("request raised outside a poll");
   a_poll_hold: assert property (
      irq_valid && !mc_tick && !vector_ack |=> irq_valid && $stable(irq_src))
      else $error("poll result changed between polls");
   a_ack_drops: assert property (vector_ack && !mc_tick |=> !irq_valid)
      else $error("request stands after vectoring");
   a_enable_gate: assert property (mc_tick ##1 irq_valid |-> ien_d[7] && ien_d[irq_src])
      else $error("disabled source won the poll");
   a_level_match: assert property (mc_tick ##1 irq_valid |-> irq_high == ipr_d[irq_src])
      else $error("winner level differs from priority bit");
   a_src_legal: assert property (irq_valid |-> irq_src <= dtic_pkg::SRC_SER)
      else $error("winning source out of range");
   c_vectored: cover property (vector_ack);
   c_high_win: cover property (mc_tick ##1 irq_valid && irq_high);
   c_refused: cover property (pslverr);
endmodule : dtic_top_chk
bind dtic_top dtic_top_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .vector_ack(vector_ack), .irq_valid(irq_valid), .irq_src(irq_src),
   .irq_high(irq_high), .mc_tick(mc_tick));
`default_nettype wire

// ==== sim/dtic_top_tb.sv ====
// self-checking bench for the dual timer block
`timescale 1ns/1ps
`default_nettype none
module dtic_top_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pin0, pin1, ext0, ext1, vector_ack, isr_return, irq_valid, irq_high, mc_tick;
   logic [2:0] vector_src, irq_src;
   logic [3:0] lag;
   logic [31:0] rd_q[$];
   logic [2:0] vec_q[$];
   int err_total, n_tests, seed, i, k;
   // per mode: high byte, low byte, expected control, expected high byte
   logic [31:0] mt[4] = '{32'hFF1F3000, 32'hFF1F10FF, 32'hA5FF30A5, 32'h00FF3000};
   dtic_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .count_pin0(pin0), .count_pin1(pin1), .ext_request_pin0(ext0),
      .ext_request_pin1(ext1), .vector_ack(vector_ack), .vector_src(vector_src),
      .isr_return(isr_return), .irq_valid(irq_valid), .irq_src(irq_src),
      .irq_high(irq_high), .mc_tick(mc_tick));
   dtic_core_model core (.pclk(pclk), .presetn(presetn), .irq_valid(irq_valid),
      .irq_src(irq_src), .lag(lag), .vector_ack(vector_ack), .vector_src(vector_src),
      .isr_return(isr_return));
   // free-running 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: read %h, expected %h", $time, got, exp);
      end
   endtask : chk_rd
   task automatic chk_vec(input logic [2:0] got, input logic [2:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: vector %h, expected %h", $time, got, exp);
      end
   endtask : chk_vec
   // one apb transfer; the request stands until ready is seen at a falling edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h000000, d};
      if (!wr) rd_q.push_back({24'h000000, d});
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         complete_run;
      end
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] d);
      apb(1'b0, a, d);
   endtask : rd
   // wait, bounded, until every expected vector has been seen
   task automatic drain;
      int n;
      n = 0;
      while (vec_q.size() > 0 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 400) begin
         err_total++;
         complete_run;
      end
   endtask : drain
   // results are judged mid-cycle, where ready and vector pulses have settled
   always @(negedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk_rd(prdata, rd_q.size() > 0 ? rd_q.pop_front() : 32'hFFFFFFFF);
      if (vector_ack === 1'b1) chk_vec(vector_src, vec_q.size() > 0 ? vec_q.pop_front() : 3'h7);
   end
   // main sequence
   initial begin
      seed = 32'hD789;
      err_total = 0;
      n_tests = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {pin0, pin1, ext0, ext1, lag} = {4'b0011, 4'h0};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 11; i++) rd(8'(4 * i), 8'h00);
      $display("test reset done");
      wr(dtic_pkg::OFS_IEN, 8'hFF);
      rd(dtic_pkg::OFS_IEN, 8'h9F);
      wr(dtic_pkg::OFS_IPR, 8'hFF);
      rd(dtic_pkg::OFS_IPR, 8'h1F);
      k = $random(seed);
      wr(dtic_pkg::OFS_MODE, 8'(k));
      rd(dtic_pkg::OFS_MODE, 8'(k));
      wr(dtic_pkg::OFS_IEN, 8'h00);
      wr(dtic_pkg::OFS_IPR, 8'h00);
      $display("test registers done");
      // each mode starts its low byte one step from a 5-bit or 8-bit wrap; 1F flags in mode 0 only, so modes 0 and 1 check the width
      for (i = 0; i < 4; i++) begin
         wr(dtic_pkg::OFS_MODE, 8'(i));
         wr(dtic_pkg::OFS_HB0, mt[i][31:24]);
         wr(dtic_pkg::OFS_LB0, mt[i][23:16]);
         wr(dtic_pkg::OFS_CTRL, 8'h10);
         repeat (30) @(posedge pclk);
         rd(dtic_pkg::OFS_CTRL, mt[i][15:8]);
         rd(dtic_pkg::OFS_HB0, mt[i][7:0]);
         wr(dtic_pkg::OFS_CTRL, 8'h00);
      end
      $display("test modes done");
      // gated timer 0 waits for its pin while timer 1 sits frozen in mode 3
      ext0 <= 1'b0;
      wr(dtic_pkg::OFS_MODE, 8'h39);
      wr(dtic_pkg::OFS_LB0, 8'hFF);
      wr(dtic_pkg::OFS_HB0, 8'hFF);
      wr(dtic_pkg::OFS_LB1, 8'h10);
      wr(dtic_pkg::OFS_CTRL, 8'h50);
      repeat (40) @(posedge pclk);
      rd(dtic_pkg::OFS_LB0, 8'hFF);
      rd(dtic_pkg::OFS_LB1, 8'h10);
      ext0 <= 1'b1;
      repeat (40) @(posedge pclk);
      rd(dtic_pkg::OFS_CTRL, 8'h72);
      wr(dtic_pkg::OFS_CTRL, 8'h00);
      $display("test gate done");
      // counter function: every pin fall steps the low byte once
      k = 1 + ($random(seed) & 3);
      wr(dtic_pkg::OFS_MODE, 8'h05);
      wr(dtic_pkg::OFS_LB0, 8'h00);
      wr(dtic_pkg::OFS_CTRL, 8'h10);
      repeat (k) begin
         pin0 <= 1'b1;
         repeat (24) @(posedge pclk);
         pin0 <= 1'b0;
         repeat (24) @(posedge pclk);
      end
      rd(dtic_pkg::OFS_LB0, 8'(k));
      wr(dtic_pkg::OFS_CTRL, 8'h00);
      $display("test counter done");
      // serial request held off by the global bit, then served with its flags left up
      lag <= 4'($random(seed) & 3);
      wr(dtic_pkg::OFS_IEN, 8'h1F);
      wr(dtic_pkg::OFS_SER, 8'h03);
      repeat (40) @(posedge pclk);
      vec_q.push_back(dtic_pkg::SRC_SER);
      wr(dtic_pkg::OFS_IEN, 8'h9F);
      drain;
      rd(dtic_pkg::OFS_SER, 8'h03);
      wr(dtic_pkg::OFS_SER, 8'h00);
      wr(dtic_pkg::OFS_IEN, 8'h00);
      repeat (40) @(posedge pclk);
      // falling edge on request pin 0, flag dropped when vectored
      wr(dtic_pkg::OFS_CTRL, 8'h01);
      ext0 <= 1'b0;
      repeat (30) @(posedge pclk);
      rd(dtic_pkg::OFS_CTRL, 8'h03);
      ext0 <= 1'b1;
      vec_q.push_back(dtic_pkg::SRC_EXT0);
      wr(dtic_pkg::OFS_IEN, 8'h81);
      drain;
      rd(dtic_pkg::OFS_CTRL, 8'h01);
      wr(dtic_pkg::OFS_IEN, 8'h00);
      repeat (40) @(posedge pclk);
      // two flags raised together: fixed order first, then timer 0 promoted to high level
      for (i = 0; i < 2; i++) begin
         lag <= 4'(3 * i);
         wr(dtic_pkg::OFS_IPR, 8'(2 * i));
         wr(dtic_pkg::OFS_CTRL, 8'h23);
         vec_q.push_back(i ? dtic_pkg::SRC_TMR0 : dtic_pkg::SRC_EXT0);
         vec_q.push_back(i ? dtic_pkg::SRC_EXT0 : dtic_pkg::SRC_TMR0);
         wr(dtic_pkg::OFS_IEN, 8'h83);
         drain;
         rd(dtic_pkg::OFS_CTRL, 8'h01);
         wr(dtic_pkg::OFS_IEN, 8'h00);
         repeat (40) @(posedge pclk);
      end
      $display("test interrupts done");
      complete_run;
   end
endmodule : dtic_top_tb
`default_nettype wire
